/* File: core/stat_err_counters.sv */
`timescale 1ns/1ps
`include "stat_err_consts.svh"

// Function
// R1 - 8-bit late collision frame counter
// R2 - Late collision also pulses general collision
// R3 - 8-bit counter of sixteen-collision abandons
// R4 - 8-bit transmit underrun counter
// R5 - Underrun frame bumps no other counter
// R6 - 8-bit carrier sense error counter
// R7 - Carrier errors counted only in half duplex
// R8 - Carrier error touches no other counter
// R9 - 16-bit no-buffer receive drop counter
// R10 - 8-bit receive overrun counter
// R11 - 8-bit receive symbol error counter
// R12 - Symbol error adds CRC/align or jabber
// R13 - 8-bit clean too-long frame counter
// R14 - 8-bit errored too-long jabber counter
// R15 - 8-bit clean undersize frame counter
// R16 - 8-bit heartbeat test failure, half duplex
// R17 - 8-bit short-versus-length-field counter
// R18 - Length check only when enable bit set
// R19 - Type IDs and too-long frames excluded
// R20 - Big-frame bit raises limit to 1536
// R21 - Count by one; write loads value
module stat_err_counters #(
    parameter int NARROW_W = `WIDTH_NARROW,
    parameter int WIDE_W   = `WIDTH_WIDE
) (
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  hsel_in,
    input  wire logic [11:0]           haddr_in,
    input  wire logic [1:0]            htrans_in,
    input  wire logic                  hwrite_in,
    input  wire logic [2:0]            hsize_in,
    input  wire logic [31:0]           hwdata_in,
    input  wire logic                  hready_in,
    output logic      [31:0]           hrdata_out,
    output logic                       hreadyout_out,
    output logic                       hresp_out,
    input  wire logic [31:0]           net_config_in,
    input  wire logic                  half_duplex_in,
    input  wire stat_err_pkg::tx_event_t tx_event_in,
    input  wire stat_err_pkg::rx_event_t rx_event_in,
    output logic                       collision_pulse_out,
    output logic                       crc_error_pulse_out,
    output logic                       align_error_pulse_out
);
    import stat_err_pkg::*;

    localparam int N = `NUM_COUNTERS;

    logic [15:0]    count [N];
    logic [N-1:0]   bump;
    bus_phase_t     phase;
    logic [3:0]     wr_index;
    logic           wr_valid;
    logic [13:0]    len_limit;
    logic           big_frame;
    logic           len_check;
    logic           rx_errored;
    logic           rx_too_long;
    logic           rx_valid_len;
    logic           tx_clean;
    logic [4:0]     addr_dec;
    logic [N-1:0]   load;
    logic           rd_take;

    // Counter index from byte address, flag for unmapped word
    function automatic logic [4:0] decode(input logic [11:0] addr);
        logic [4:0] r;
        r = {1'b1, 4'h0};
        if (addr[11:6] == 6'h00 && addr[5:2] < 4'(N)) begin
            r = {1'b0, addr[5:2]};
        end
        return r;
    endfunction

    // Width per counter: only the no-buffer counter is wide
    function automatic logic [15:0] width_mask(input int idx);
        logic [15:0] m;
        m = 16'((32'h1 << NARROW_W) - 32'h1);
        if (idx == 4) begin
            m = 16'((32'h1 << WIDE_W) - 32'h1);
        end
        return m;
    endfunction

    // Frame qualification
    assign big_frame    = net_config_in[`CFG_BIG_FRAME_BIT];
    assign len_check    = net_config_in[`CFG_LEN_CHECK_BIT];
    assign len_limit    = big_frame ? `LEN_MAX_BIG : `LEN_MAX_STD; // R20
    assign rx_errored   = rx_event_in.crc_error | rx_event_in.symbol_error;
    assign rx_too_long  = rx_event_in.length > len_limit;
    assign rx_valid_len = !rx_too_long && rx_event_in.length >= `LEN_MIN;
    assign tx_clean     = tx_event_in.frame_done && !tx_event_in.underrun; // R5

    // Shared address decode and read request
    assign addr_dec = decode(haddr_in);
    assign rd_take  = hready_in && hsel_in && htrans_in == `HTRANS_NONSEQ && !hwrite_in;

    // Per-counter load strobe during a write data phase
    always_comb begin
        for (int k = 0; k < N; k++) begin
            load[k] = phase == PHASE_WRITE && wr_valid && wr_index == 4'(k);
        end
    end

    // Event strobes per counter
    always_comb begin
        bump     = '0;
        bump[0]  = tx_clean && tx_event_in.late_collision; // R1
        bump[1]  = tx_clean && tx_event_in.excess_collision; // R3
        bump[2]  = tx_event_in.frame_done && tx_event_in.underrun; // R4
        bump[3]  = tx_clean && half_duplex_in && tx_event_in.carrier_lost // R6 R7 R8
                   && !tx_event_in.late_collision && !tx_event_in.excess_collision;
        bump[4]  = rx_event_in.frame_done && rx_event_in.no_buffer; // R9
        bump[5]  = rx_event_in.frame_done && rx_event_in.overrun; // R10
        bump[6]  = rx_event_in.frame_done && rx_event_in.symbol_error; // R11
        bump[7]  = rx_event_in.frame_done && rx_too_long && !rx_errored; // R13
        bump[8]  = rx_event_in.frame_done && rx_too_long && rx_errored; // R14 R12
        bump[9]  = rx_event_in.frame_done && !rx_errored
                   && rx_event_in.length < `LEN_MIN; // R15
        bump[10] = tx_clean && half_duplex_in && tx_event_in.heartbeat_missing; // R16
        bump[11] = rx_event_in.frame_done && len_check && !rx_too_long // R17 R18 R19
                   && rx_event_in.length_type < `TYPE_ID_MIN
                   && {2'b00, rx_event_in.length} < rx_event_in.length_type;
    end

    // Strobes handed to the counters that live elsewhere
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            collision_pulse_out   <= 1'b0;
            crc_error_pulse_out   <= 1'b0;
            align_error_pulse_out <= 1'b0;
        end else begin
            collision_pulse_out   <= tx_clean && tx_event_in.late_collision; // R2
            crc_error_pulse_out   <= rx_event_in.frame_done && rx_valid_len // R12
                                     && rx_errored && !rx_event_in.odd_bits;
            align_error_pulse_out <= rx_event_in.frame_done && rx_valid_len
                                     && rx_errored && rx_event_in.odd_bits;
        end
    end

    // AHB address phase capture for writes
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            phase    <= PHASE_IDLE;
            wr_index <= 4'h0;
            wr_valid <= 1'b0;
        end else if (hready_in) begin
            phase    <= PHASE_IDLE;
            wr_valid <= 1'b0;
            if (hsel_in && htrans_in == `HTRANS_NONSEQ && hwrite_in) begin
                phase    <= PHASE_WRITE;
                wr_index <= addr_dec[3:0];
                wr_valid <= !addr_dec[4];
            end
        end
    end

    // AHB read data registered at the address phase
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (hready_in) begin
            hrdata_out <= 32'h0000_0000;
            if (rd_take && !addr_dec[4]) begin
                hrdata_out <= {16'h0000, count[addr_dec[3:0]]};
                // Forward a write still in its data phase to the same word
                if (load[addr_dec[3:0]]) begin
                    hrdata_out <= {16'h0000, hwdata_in[15:0] & width_mask(int'(addr_dec[3:0]))};
                end
            end
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // Counters: write loads, otherwise step by one and wrap
    generate
        for (genvar i = 0; i < N; i++) begin : g_cnt
            always_ff @(posedge clk_in) begin
                if (!resetn_in) begin
                    count[i] <= `COUNT_RESET;
                end else if (load[i]) begin
                    count[i] <= hwdata_in[15:0] & width_mask(i); // R21
                end else if (bump[i]) begin
                    count[i] <= (count[i] + 16'h0001) & width_mask(i); // R21
                end
            end
        end
    endgenerate

    // Assertions
    property p_underrun_alone;
        @(posedge clk_in) disable iff (!resetn_in)
        (tx_event_in.frame_done && tx_event_in.underrun) |-> !bump[0] && !bump[1]
            && !bump[3] && !bump[10] ##1 !collision_pulse_out;
    endproperty
    a_underrun_alone: assert property (p_underrun_alone) else $error("underrun bumped others"); // R5

    property p_late_double;
        @(posedge clk_in) disable iff (!resetn_in)
        bump[0] |=> collision_pulse_out;
    endproperty
    a_late_double: assert property (p_late_double) else $error("late collision not doubled"); // R2

    property p_carrier_full;
        @(posedge clk_in) disable iff (!resetn_in)
        (!half_duplex_in && !load[3]) |=> count[3] == $past(count[3]);
    endproperty
    a_carrier_full: assert property (p_carrier_full) else $error("carrier count in full duplex"); // R7

    property p_carrier_only;
        @(posedge clk_in) disable iff (!resetn_in)
        (tx_clean && tx_event_in.carrier_lost && !tx_event_in.late_collision)
            |=> !collision_pulse_out;
    endproperty
    a_carrier_only: assert property (p_carrier_only) else $error("carrier error side effect"); // R8

    property p_step_one;
        @(posedge clk_in) disable iff (!resetn_in)
        (bump[6] && !(phase == PHASE_WRITE && wr_valid))
            |=> count[6] == (($past(count[6]) + 16'h0001) & 16'h00ff);
    endproperty
    a_step_one: assert property (p_step_one) else $error("symbol count step wrong"); // R11

    property p_no_buf_wide;
        @(posedge clk_in) disable iff (!resetn_in)
        (bump[4] && count[4] == 16'h00ff && !(phase == PHASE_WRITE && wr_valid))
            |=> count[4] == 16'h0100;
    endproperty
    a_no_buf_wide: assert property (p_no_buf_wide) else $error("no-buffer not 16-bit"); // R9

    property p_len_check_off;
        @(posedge clk_in) disable iff (!resetn_in)
        (!len_check && !load[11]) |=> count[11] == $past(count[11]);
    endproperty
    a_len_check_off: assert property (p_len_check_off) else $error("length check while off"); // R18

    property p_type_excluded;
        @(posedge clk_in) disable iff (!resetn_in)
        ((rx_event_in.length_type >= `TYPE_ID_MIN || rx_too_long) && !load[11])
            |=> count[11] == $past(count[11]);
    endproperty
    a_type_excluded: assert property (p_type_excluded) else $error("type id counted"); // R19

    property p_limit;
        @(posedge clk_in) disable iff (!resetn_in)
        (rx_event_in.frame_done && rx_event_in.length == 14'h0600 && !rx_errored)
            |-> bump[7] == !big_frame;
    endproperty
    a_limit: assert property (p_limit) else $error("big frame limit wrong"); // R20 R13

    property p_write_load;
        @(posedge clk_in) disable iff (!resetn_in)
        (phase == PHASE_WRITE && wr_valid && wr_index == 4'h0)
            |=> count[0] == ($past(hwdata_in[15:0]) & 16'h00ff);
    endproperty
    a_write_load: assert property (p_write_load) else $error("write did not load"); // R21

    property p_late_step;
        @(posedge clk_in) disable iff (!resetn_in)
        (bump[0] && !load[0]) |=> count[0] == (($past(count[0]) + 16'h0001) & 16'h00ff);
    endproperty
    a_late_step: assert property (p_late_step) else $error("late count step wrong"); // R1

    property p_excess_step;
        @(posedge clk_in) disable iff (!resetn_in)
        (bump[1] && !load[1]) |=> count[1] == (($past(count[1]) + 16'h0001) & 16'h00ff);
    endproperty
    a_excess_step: assert property (p_excess_step) else $error("excess step wrong"); // R3

    property p_under_step;
        @(posedge clk_in) disable iff (!resetn_in)
        (bump[2] && !load[2]) |=> count[2] == (($past(count[2]) + 16'h0001) & 16'h00ff);
    endproperty
    a_under_step: assert property (p_under_step) else $error("underrun step wrong"); // R4

    property p_under_late;
        @(posedge clk_in) disable iff (!resetn_in)
        (tx_event_in.frame_done && tx_event_in.underrun && !load[0])
            |=> count[0] == $past(count[0]);
    endproperty
    a_under_late: assert property (p_under_late) else $error("underrun moved late"); // R5

    property p_nobuf_step;
        @(posedge clk_in) disable iff (!resetn_in)
        (bump[4] && !load[4]) |=> count[4] == $past(count[4]) + 16'h0001;
    endproperty
    a_nobuf_step: assert property (p_nobuf_step) else $error("no-buffer step wrong"); // R9

    property p_ovr_step;
        @(posedge clk_in) disable iff (!resetn_in)
        (bump[5] && !load[5]) |=> count[5] == (($past(count[5]) + 16'h0001) & 16'h00ff);
    endproperty
    a_ovr_step: assert property (p_ovr_step) else $error("overrun step wrong"); // R10

    property p_hb_full;
        @(posedge clk_in) disable iff (!resetn_in)
        (!half_duplex_in && !load[10]) |=> count[10] == $past(count[10]);
    endproperty
    a_hb_full: assert property (p_hb_full) else $error("heartbeat in full duplex"); // R16

    property p_long_clean;
        @(posedge clk_in) disable iff (!resetn_in)
        (rx_event_in.frame_done && rx_too_long && !rx_errored && !load[7])
            |=> count[7] == (($past(count[7]) + 16'h0001) & 16'h00ff);
    endproperty
    a_long_clean: assert property (p_long_clean) else $error("too-long step wrong"); // R13

    property p_jab_step;
        @(posedge clk_in) disable iff (!resetn_in)
        (rx_event_in.frame_done && rx_too_long && rx_errored && !load[8])
            |=> count[8] == (($past(count[8]) + 16'h0001) & 16'h00ff);
    endproperty
    a_jab_step: assert property (p_jab_step) else $error("jabber step wrong"); // R14

    property p_short_bad;
        @(posedge clk_in) disable iff (!resetn_in)
        (rx_event_in.frame_done && rx_event_in.length < `LEN_MIN && rx_errored && !load[9])
            |=> count[9] == $past(count[9]);
    endproperty
    a_short_bad: assert property (p_short_bad) else $error("errored short counted"); // R15

    property p_long_nopulse;
        @(posedge clk_in) disable iff (!resetn_in)
        (rx_event_in.frame_done && rx_too_long)
            |=> !crc_error_pulse_out && !align_error_pulse_out;
    endproperty
    a_long_nopulse: assert property (p_long_nopulse) else $error("long frame pulsed"); // R12

    property p_crc_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        (rx_event_in.frame_done && rx_valid_len && rx_errored && !rx_event_in.odd_bits)
            |=> crc_error_pulse_out;
    endproperty
    a_crc_pulse: assert property (p_crc_pulse) else $error("crc pulse missing"); // R12

    property p_align_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        (rx_event_in.frame_done && rx_valid_len && rx_errored && rx_event_in.odd_bits)
            |=> align_error_pulse_out;
    endproperty
    a_align_pulse: assert property (p_align_pulse) else $error("align pulse missing"); // R12

    property p_coll_cause;
        @(posedge clk_in) disable iff (!resetn_in)
        collision_pulse_out |-> $past(bump[0]);
    endproperty
    a_coll_cause: assert property (p_coll_cause) else $error("stray collision pulse"); // R2

    property p_read_word;
        @(posedge clk_in) disable iff (!resetn_in)
        (rd_take && haddr_in == `OFS_LATE_COLL && !load[0])
            |=> hrdata_out == {16'h0000, $past(count[0])};
    endproperty
    a_read_word: assert property (p_read_word) else $error("read data wrong"); // R21

    property p_idle_zero;
        @(posedge clk_in) disable iff (!resetn_in)
        (hready_in && !rd_take) |=> hrdata_out == 32'h0000_0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not cleared"); // R21

    c_late: cover property (@(posedge clk_in) disable iff (!resetn_in) bump[0]);
    c_jabber: cover property (@(posedge clk_in) disable iff (!resetn_in) bump[8]);
    c_mismatch: cover property (@(posedge clk_in) disable iff (!resetn_in) bump[11]);
    c_carry: cover property (@(posedge clk_in) disable iff (!resetn_in)
        bump[4] && count[4] == 16'h00ff);
    c_write: cover property (@(posedge clk_in) disable iff (!resetn_in)
        phase == PHASE_WRITE && wr_valid);

endmodule

/* File: common/stat_err_consts.svh */
`ifndef STAT_ERR_CONSTS_SVH
`define STAT_ERR_CONSTS_SVH

// Register byte offsets
`define OFS_LATE_COLL      12'h000
`define OFS_EXCESS_COLL    12'h004
`define OFS_TX_UNDERRUN    12'h008
`define OFS_CARRIER_ERR    12'h00c
`define OFS_RX_NO_BUFFER   12'h010
`define OFS_RX_OVERRUN     12'h014
`define OFS_RX_SYMBOL      12'h018
`define OFS_TOO_LONG       12'h01c
`define OFS_JABBER         12'h020
`define OFS_SHORT_FRAME    12'h024
`define OFS_HEARTBEAT_ERR  12'h028
`define OFS_LEN_MISMATCH   12'h02c
`define NUM_COUNTERS       12

// Counter widths and reset value
`define WIDTH_NARROW       8
`define WIDTH_WIDE         16
`define COUNT_RESET        16'h0000

// Frame length limits in bytes
`define LEN_MIN            14'h0040
`define LEN_MAX_STD        14'h05ee
`define LEN_MAX_BIG        14'h0600
`define TYPE_ID_MIN        16'h0600

// Configuration bit positions
`define CFG_BIG_FRAME_BIT  8
`define CFG_LEN_CHECK_BIT  16

// AHB transfer types
`define HTRANS_NONSEQ      2'b10

`endif

/* File: common/stat_err_pkg.sv */
package stat_err_pkg;

    // Transmit outcome strobe group, one frame per pulse
    typedef struct packed {
        logic frame_done;
        logic late_collision;
        logic excess_collision;
        logic underrun;
        logic carrier_lost;
        logic heartbeat_missing;
    } tx_event_t;

    // Receive outcome strobe group with frame attributes
    typedef struct packed {
        logic        frame_done;
        logic        no_buffer;
        logic        overrun;
        logic        symbol_error;
        logic        crc_error;
        logic        odd_bits;
        logic [13:0] length;
        logic [15:0] length_type;
    } rx_event_t;

    // Bus phase tracking
    typedef enum logic [0:0] {
        PHASE_IDLE  = 1'b0,
        PHASE_WRITE = 1'b1
    } bus_phase_t;

endpackage

/* File: bench/mac_event_source.sv */
`timescale 1ns/1ps
// Frame-outcome strobes of the MAC transmit and receive paths
module mac_event_source (
    input  wire logic                    clk_in,
    input  wire stat_err_pkg::tx_event_t tx_req_in,
    input  wire stat_err_pkg::rx_event_t rx_req_in,
    output stat_err_pkg::tx_event_t      tx_event_out,
    output stat_err_pkg::rx_event_t      rx_event_out
);
    import stat_err_pkg::*;
    // Quiet strobes at start
    initial begin
        tx_event_out = '0;
        rx_event_out = '0;
    end
    // One-cycle strobes; qualifiers churn between frames so stale values never pass
    always @(posedge clk_in) begin
        tx_event_out <= tx_req_in.frame_done ? tx_req_in : {1'b0, ~tx_event_out[4:0]};
        rx_event_out <= rx_req_in.frame_done ? rx_req_in : {1'b0, ~rx_event_out[34:0]};
    end
endmodule

/* File: bench/mac_error_statistics_counters_tb_top.sv */
`timescale 1ns/1ps
`include "stat_err_consts.svh"
module mac_error_statistics_counters_tb_top;
    import stat_err_pkg::*;
    localparam logic [13:0] LENS [6] = '{14'd63, 14'd64, 14'd1518, 14'd1519, 14'd1536, 14'd1537};
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        hsel_in = 1'b0;
    logic [11:0] haddr_in = '0;
    logic [1:0]  htrans_in = '0;
    logic        hwrite_in = 1'b0;
    logic [31:0] hwdata_in = '0;
    logic [31:0] net_config_in = '0;
    logic        half_duplex_in = 1'b1;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        hresp_out;
    logic        collision_pulse_out;
    logic        crc_error_pulse_out;
    logic        align_error_pulse_out;
    tx_event_t   tx_req = '0;
    tx_event_t   tx_event_in;
    rx_event_t   rx_req = '0;
    rx_event_t   rx_event_in;
    logic [31:0] seed = 32'h0b3c;
    logic [31:0] cycles = '0;
    logic [31:0] rd;
    logic [31:0] exp_cnt [12];
    int          n_errors = 0;
    int          checks_done = 0;

    stat_err_counters stat_err_counters_i (.clk_in(clk_in), .resetn_in(resetn_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(3'b010), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .net_config_in(net_config_in), .half_duplex_in(half_duplex_in),
        .tx_event_in(tx_event_in), .rx_event_in(rx_event_in),
        .collision_pulse_out(collision_pulse_out), .crc_error_pulse_out(crc_error_pulse_out),
        .align_error_pulse_out(align_error_pulse_out));
    mac_event_source mac_event_source_i (.clk_in(clk_in), .tx_req_in(tx_req),
        .rx_req_in(rx_req), .tx_event_out(tx_event_in), .rx_event_out(rx_event_in));

    // Clock and hang guard
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 32'd40000) begin
            n_errors++;
            wrap_up();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] wmask(int i);
        return (i == 4) ? 32'h0000ffff : 32'h000000ff;
    endfunction
    // Counters a transmit outcome should advance
    function automatic logic [11:0] tx_inc(tx_event_t e, logic hd);
        logic [11:0] m;
        m = '0;
        if (!e.frame_done) return m;
        if (e.underrun) return 12'h004;
        m[0] = e.late_collision;
        m[1] = e.excess_collision;
        m[3] = e.carrier_lost & hd & !e.late_collision & !e.excess_collision;
        m[10] = e.heartbeat_missing & hd;
        return m;
    endfunction
    // Counters a receive outcome should advance
    function automatic logic [11:0] rx_inc(rx_event_t e, logic [31:0] cfg);
        logic [11:0] m;
        logic        bad;
        logic        over;
        m = '0;
        if (!e.frame_done) return m;
        bad = e.crc_error | e.symbol_error;
        over = e.length > (cfg[`CFG_BIG_FRAME_BIT] ? `LEN_MAX_BIG : `LEN_MAX_STD);
        m[4] = e.no_buffer;
        m[5] = e.overrun;
        m[6] = e.symbol_error;
        m[7] = over & !bad;
        m[8] = over & bad;
        m[9] = (e.length < `LEN_MIN) & !bad;
        m[11] = cfg[`CFG_LEN_CHECK_BIT] & (e.length_type < `TYPE_ID_MIN) & !over
            & ({2'b00, e.length} < e.length_type);
        return m;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    // One single AHB-Lite transfer
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= wr;
        htrans_in <= `HTRANS_NONSEQ;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hsel_in <= 1'b0;
        hwdata_in <= wd;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        q = hrdata_out;
    endtask
    task automatic check_all();
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, 12'(i * 4), '0, rd);
            cmp(rd, exp_cnt[i]);
        end
        cmp(32'(hresp_out), 32'h0000_0000);
    endtask
    // Send one outcome per direction and predict its effect
    task automatic fire(input tx_event_t t, input rx_event_t r);
        logic [11:0] m;
        logic        ok_len;
        logic        bad;
        tx_req <= t;
        rx_req <= r;
        @(posedge clk_in);
        tx_req <= '0;
        rx_req <= '0;
        m = tx_inc(t, half_duplex_in) | rx_inc(r, net_config_in);
        bad = r.frame_done & (r.crc_error | r.symbol_error);
        ok_len = r.length >= `LEN_MIN
            && r.length <= (net_config_in[`CFG_BIG_FRAME_BIT] ? `LEN_MAX_BIG : `LEN_MAX_STD);
        for (int i = 0; i < 12; i++)
            if (m[i]) exp_cnt[i] = (exp_cnt[i] + 1) & wmask(i);
        @(posedge clk_in);
        @(negedge clk_in);
        cmp(32'(collision_pulse_out), 32'(t.frame_done & t.late_collision & !t.underrun));
        cmp(32'(crc_error_pulse_out), 32'(bad & ok_len & !r.odd_bits));
        cmp(32'(align_error_pulse_out), 32'(bad & ok_len & r.odd_bits));
        @(posedge clk_in);
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Reset, register access, then random outcomes with corner lengths
    initial begin
        tx_event_t   t;
        rx_event_t   r;
        logic [31:0] v;
        for (int i = 0; i < 12; i++) exp_cnt[i] = '0;
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        check_all();
        bus(1'b0, 12'h030, '0, rd);
        cmp(rd, '0);
        for (int i = 0; i < 12; i++) begin
            v = xs();
            bus(1'b1, 12'(i * 4), v, rd);
            exp_cnt[i] = v & wmask(i);
        end
        bus(1'b1, 12'h030, '1, rd);
        check_all();
        // Corner: carry out of bit 7 in the narrow and the wide counter
        bus(1'b1, `OFS_LATE_COLL, 32'h0000_00ff, rd);
        bus(1'b1, `OFS_RX_NO_BUFFER, 32'h0000_00ff, rd);
        exp_cnt[0] = 32'h0000_00ff;
        exp_cnt[4] = 32'h0000_00ff;
        t = '0;
        t.frame_done = 1'b1;
        t.late_collision = 1'b1;
        r = '0;
        r.frame_done = 1'b1;
        r.no_buffer = 1'b1;
        r.length = 14'd100;
        r.length_type = 16'h0800;
        fire(t, r);
        check_all();
        for (int n = 0; n < 150; n++) begin
            v = xs();
            net_config_in <= xs();
            half_duplex_in <= v[9];
            t = tx_event_t'(6'(xs()));
            t.frame_done = v[20];
            r = rx_event_t'(36'({xs(), xs()}));
            r.frame_done = v[21];
            r.length = (v[2:0] < 3'd6) ? LENS[v[2:0]] : (r.length & 14'h07ff);
            if (v[3]) r.length_type = {2'b00, r.length} + 16'(v[5:4]) - 16'd1;
            else r.length_type &= 16'h0fff;
            if (v[8:6] == 3'd0) r.length_type = 16'h05ff + 16'(v[10]);
            r.no_buffer &= v[11];
            r.overrun &= !r.no_buffer;
            if (r.no_buffer | r.overrun) begin
                r.crc_error = 1'b0;
                r.symbol_error = 1'b0;
                r.length = 14'd100;
                r.length_type = 16'h0800;
            end
            fire(t, r);
            check_all();
        end
        wrap_up();
    end
endmodule
